/* hdl/timer_pkg.sv */
// shared constants, modes and state layout of the gated interval timer
package timer_pkg;

  // ==========================================================
  // count values
  localparam logic [15:0] COUNT_RESET   = 16'h0000; // wrap value
  localparam logic [15:0] COUNT_STEP    = 16'h0001; // one increment

  // ==========================================================
  // prescale select encodings
  localparam logic [1:0]  PSC_SEL_1     = 2'h0;     // 1:1
  localparam logic [1:0]  PSC_SEL_8     = 2'h1;     // 1:8
  localparam logic [1:0]  PSC_SEL_64    = 2'h2;     // 1:64
  localparam logic [1:0]  PSC_SEL_256   = 2'h3;     // 1:256

  // last prescale count (N-1) per setting
  localparam logic [7:0]  PSC_LAST_1    = 8'h00;
  localparam logic [7:0]  PSC_LAST_8    = 8'h07;
  localparam logic [7:0]  PSC_LAST_64   = 8'h3F;
  localparam logic [7:0]  PSC_LAST_256  = 8'hFF;

  // last hold count (N/2-1) after a period match
  localparam logic [7:0]  HOLD_LAST_1   = 8'h00;
  localparam logic [7:0]  HOLD_LAST_8   = 8'h03;
  localparam logic [7:0]  HOLD_LAST_64  = 8'h1F;
  localparam logic [7:0]  HOLD_LAST_256 = 8'h7F;

  // ==========================================================
  // synchronisation depths in external clock edges, and the priority that turns the irq off
  localparam logic [1:0]  START_EDGES   = 2'h2;     // after enable
  localparam logic [1:0]  WRITE_EDGES   = 2'h2;     // count write
  localparam logic [2:0]  PRIO_OFF      = 3'h0;     // irq disabled

  // ==========================================================
  // run states, one-hot
  typedef enum logic [2:0] {
    RUN_IDLE  = 3'b001,
    RUN_ARM   = 3'b010,
    RUN_COUNT = 3'b100
  } run_e;

  // control bits from software
  typedef struct packed {
    logic       enable;            // timer on
    logic       clockSourceSelect; // 1 = pin clock
    logic       extSyncSelect;     // 1 = synchronous external
    logic [1:0] prescaleSelect;    // divider choice
    logic       gateAccumEnable;   // gated accumulation
    logic       asyncWriteBlock;   // drop writes while pending
  } timer_cfg_s;

  // interrupt settings from software
  typedef struct packed {
    logic       timerIrqEnable;
    logic [2:0] irqPriority;
    logic [1:0] irqSubpriority;
  } irq_cfg_s;

  // whole state of the timer core
  typedef struct packed {
    run_e        run;
    logic [15:0] count;
    logic [7:0]  psc;
    logic [7:0]  hold;
    logic [1:0]  startEdges;
    logic        pending;
    logic [1:0]  writeEdges;
    logic [15:0] writeData;
    logic        gateRun;
    logic [15:0] readDly1;
    logic [15:0] readDly2;
    logic        eventFlag;
    logic        matchPulse;
    logic        gatePulse;
    logic [2:0]  prioOut;
    logic [1:0]  subOut;
  } timer_state_s;

  localparam timer_state_s STATE_RESET = '{run: RUN_IDLE, default: '0};

endpackage

/* hdl/pin_sync_edge.sv */
// two-stage pin synchroniser with rising and falling edge pulses
module pin_sync_edge (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  // ==========================================================
  // state
  typedef struct packed {
    logic meta;   // first stage, read only by second
    logic sync;   // synchronised level
    logic last;   // previous synchronised level
  } sync_state_s;

  sync_state_s st_r;   // registered state
  sync_state_s st_nxt; // next state

  // shift the pin through the stages
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pinIn;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  // register the stages
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.sync;
  assign rise  = st_r.sync & ~st_r.last;
  assign fall  = ~st_r.sync & st_r.last;

endmodule

/* hdl/gated_interval_timer.sv */
// 16-bit interval timer: pin clock, gated bus clock, prescaler, flag
// Behaviour
// - pin edges advance count at 1:1
// - match event, then wrap to zero, repeating
// - prescale N advances once per N edges
// - two pin edges wait after enable
// - pin counting continues during processor sleep
// - pending flag high while write synchronises
// - blocking mode drops writes while pending
// - pending reads zero in synchronous modes
// - written value lands after two pin edges
// - async read returns count two cycles old
// - gated: rising gate starts bus-clock counting
// - gated: wrap at period without match event
// - falling gate stops count, raises gate event
// - prescale divides by 1, 8, 64, 256
// - prescaler cleared on reset, disable, write
// - prescaler resynchronises over two pin edges
// - match value held N/2 ticks before wrap
// - events set flag; irq only when enabled
// - flag stays set until software clears
// - priority zero blocks the interrupt request
// - disable stops timer, keeps settings
module gated_interval_timer (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  deviceResetNoPor,
  input  wire timer_pkg::timer_cfg_s cfg,
  input  wire timer_pkg::irq_cfg_s   irqCfg,
  input  wire logic                  extClockGatePin,
  input  wire logic                  sleepMode,
  input  wire logic                  countWrite,
  input  wire logic [15:0]           countWriteData,
  input  wire logic [15:0]           periodValue,
  input  wire logic                  flagClear,
  output logic [15:0]                countValue,
  output logic                       asyncWritePending,
  output logic                       timerEventFlag,
  output logic                       irqRequest,
  output logic [2:0]                 irqPriorityOut,
  output logic [1:0]                 irqSubpriorityOut,
  output logic                       matchEvent,
  output logic                       gateEvent
);
  import timer_pkg::*;

  // ==========================================================
  // pin synchroniser
  logic extRise;   // pin rising edge pulse
  logic extFall;   // pin falling edge pulse

  // pin passes two flops before any edge logic
  pin_sync_edge u_pin_sync (
    .clock (clock),
    .rstn  (rstn),
    .pinIn (extClockGatePin),
    .level (),
    .rise  (extRise),
    .fall  (extFall)
  );

  // ==========================================================
  // mode decode
  timer_state_s st_r;       // registered state
  timer_state_s st_nxt;     // next state
  logic         extMode;    // pin is the count source
  logic         asyncMode;  // pin source, not synchronous
  logic         gatedMode;  // bus clock gated by pin
  logic         counting;   // running and enabled
  logic         srcTick;    // one source clock
  logic         atPeriod;   // count equals period
  logic         advance;    // count increments this cycle
  logic [7:0]   pscLast;    // last prescale count
  logic [7:0]   holdLast;   // last hold count

  assign extMode   = cfg.clockSourceSelect;
  assign asyncMode = cfg.clockSourceSelect & ~cfg.extSyncSelect;
  // sync bit ignored with the internal source
  assign gatedMode = ~cfg.clockSourceSelect & cfg.gateAccumEnable;
  assign counting  = cfg.enable & (st_r.run == RUN_COUNT);
  assign atPeriod  = st_r.count == periodValue;

  // pin ticks ignore sleep; bus clock halts in sleep
  always_comb begin
    if (extMode) begin
      srcTick = extRise;
    end else if (gatedMode) begin
      srcTick = ~sleepMode & st_r.gateRun;
    end else begin
      srcTick = ~sleepMode;
    end
  end

  // divider and hold lengths per prescale setting
  always_comb begin
    case (cfg.prescaleSelect)
      PSC_SEL_1: begin
        pscLast  = PSC_LAST_1;
        holdLast = HOLD_LAST_1;
      end
      PSC_SEL_8: begin
        pscLast  = PSC_LAST_8;
        holdLast = HOLD_LAST_8;
      end
      PSC_SEL_64: begin
        pscLast  = PSC_LAST_64;
        holdLast = HOLD_LAST_64;
      end
      PSC_SEL_256: begin
        pscLast  = PSC_LAST_256;
        holdLast = HOLD_LAST_256;
      end
      default: begin
        pscLast  = PSC_LAST_1;
        holdLast = HOLD_LAST_1;
      end
    endcase
  end

  // one increment per N ticks, never past the period
  assign advance = counting & srcTick & (st_r.psc == pscLast)
                 & ~atPeriod;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt            = st_r;
    st_nxt.matchPulse = 1'b0;
    st_nxt.gatePulse  = 1'b0;

    // start-up sequencing
    case (st_r.run)
      RUN_IDLE: begin
        st_nxt.startEdges = 2'h0;
        if (cfg.enable) begin
          // pin source waits for the prescaler to resync
          st_nxt.run = extMode ? RUN_ARM : RUN_COUNT;
        end
      end
      RUN_ARM: begin
        if (extRise) begin
          st_nxt.startEdges = st_r.startEdges + 2'h1;
          if (st_r.startEdges == START_EDGES - 2'h1) begin
            st_nxt.run = RUN_COUNT;
          end
        end
      end
      RUN_COUNT: begin
        st_nxt.run = RUN_COUNT;
      end
      default: begin
        st_nxt.run = RUN_IDLE;
      end
    endcase

    // counting and period handling
    if (counting && srcTick) begin
      if (atPeriod) begin
        // hold the match value, then wrap
        if (st_r.hold == holdLast) begin
          st_nxt.count = COUNT_RESET;
          st_nxt.hold  = 8'h00;
          st_nxt.psc   = 8'h00;
        end else begin
          st_nxt.hold = st_r.hold + 8'h01;
        end
      end else if (st_r.psc == pscLast) begin
        st_nxt.psc   = 8'h00;
        st_nxt.count = st_r.count + COUNT_STEP;
        // match only outside gated mode
        if ((st_r.count + COUNT_STEP) == periodValue && !gatedMode) begin
          st_nxt.matchPulse = 1'b1;
        end
      end else begin
        st_nxt.psc = st_r.psc + 8'h01;
      end
    end

    // gate edges start and stop accumulation
    if (gatedMode && cfg.enable) begin
      if (extRise) begin
        st_nxt.gateRun = 1'b1;
      end
      if (extFall) begin
        st_nxt.gateRun   = 1'b0;
        st_nxt.gatePulse = 1'b1;
      end
    end

    // disable stops counting and the gate, clears prescaler and hold, keeps count and settings
    if (!cfg.enable) begin
      st_nxt.run     = RUN_IDLE;
      st_nxt.psc     = 8'h00;
      st_nxt.hold    = 8'h00;
      st_nxt.gateRun = 1'b0;
    end

    // device reset other than power-on clears prescaler
    if (deviceResetNoPor) begin
      st_nxt.psc = 8'h00;
    end

    // count writes
    if (countWrite) begin
      if (asyncMode) begin
        // blocking mode drops writes while one is pending
        if (!(st_r.pending && cfg.asyncWriteBlock)) begin
          st_nxt.writeData  = countWriteData;
          st_nxt.pending    = 1'b1;
          st_nxt.writeEdges = 2'h0;
        end
      end else begin
        st_nxt.count = countWriteData;
        st_nxt.psc   = 8'h00;
        st_nxt.hold  = 8'h00;
      end
    end else if (st_r.pending && extRise) begin
      st_nxt.writeEdges = st_r.writeEdges + 2'h1;
      if (st_r.writeEdges == WRITE_EDGES - 2'h1) begin
        st_nxt.count   = st_r.writeData;
        st_nxt.psc     = 8'h00;
        st_nxt.hold    = 8'h00;
        st_nxt.pending = 1'b0;
      end
    end

    // synchronous modes never hold a pending write
    if (!asyncMode) begin
      st_nxt.pending = 1'b0;
    end

    // event flag: set wins over clear
    st_nxt.eventFlag = (st_r.eventFlag & ~flagClear)
                     | st_r.matchPulse | st_r.gatePulse;

    // read path lags two cycles
    st_nxt.readDly1 = st_r.count;
    st_nxt.readDly2 = st_r.readDly1;

    // interrupt settings carried to the controller
    st_nxt.prioOut = irqCfg.irqPriority;
    st_nxt.subOut  = irqCfg.irqSubpriority;
  end

  // register the state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign countValue        = asyncMode ? st_r.readDly2 : st_r.count;
  assign asyncWritePending = st_r.pending & asyncMode;
  assign timerEventFlag    = st_r.eventFlag;
  // request only when enabled and priority non-zero
  assign irqRequest        = st_r.eventFlag & irqCfg.timerIrqEnable
                           & (irqCfg.irqPriority != PRIO_OFF);
  assign irqPriorityOut    = st_r.prioOut;
  assign irqSubpriorityOut = st_r.subOut;
  assign matchEvent        = st_r.matchPulse;
  assign gateEvent         = st_r.gatePulse;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_event;
    matchEvent || gateEvent;
  endsequence

  sequence s_wrap_due;
    counting && srcTick && atPeriod && st_r.hold == holdLast
      && !countWrite && !st_r.pending;
  endsequence

  a_flag_set_delay: assert property (s_event |-> ##[1:3] timerEventFlag)
    else $error("event did not set flag in time");

  a_flag_sticky_hold: assert property (
    timerEventFlag && !flagClear |=> timerEventFlag)
    else $error("flag cleared without software");

  a_irq_needs_prio: assert property (
    irqRequest |-> irqCfg.timerIrqEnable && irqCfg.irqPriority != PRIO_OFF)
    else $error("irq raised while disabled");

  a_pend_sync_zero: assert property (!asyncMode |=> !st_r.pending)
    else $error("pending set in sync mode");

  a_pend_on_write: assert property (
    countWrite && asyncMode && !(st_r.pending && cfg.asyncWriteBlock)
    && $stable(cfg) |=> asyncWritePending)
    else $error("write did not raise pending");

  a_write_block_drop: assert property (
    countWrite && asyncMode && cfg.asyncWriteBlock && st_r.pending
    |=> st_r.writeData == $past(st_r.writeData))
    else $error("blocked write was taken");

  a_read_two_back: assert property (
    asyncMode && $stable(cfg) |-> countValue == $past(st_r.count, 2))
    else $error("async read not two cycles old");

  a_gate_stop_event: assert property (
    gatedMode && cfg.enable && extFall |=> gateEvent && !st_r.gateRun)
    else $error("gate fall did not stop timer");

  a_gate_count_hold: assert property (
    gateEvent && !countWrite && !extRise && $stable(cfg)
    |=> st_r.count == $past(st_r.count))
    else $error("count moved after gate stop");

  a_gated_no_match: assert property (gatedMode |-> !matchEvent)
    else $error("match event in gated mode");

  a_arm_on_enable: assert property (
    st_r.run == RUN_IDLE && cfg.enable && extMode |=> st_r.run == RUN_ARM)
    else $error("pin source skipped start wait");

  a_wrap_to_zero: assert property (s_wrap_due |=> st_r.count == COUNT_RESET)
    else $error("no wrap after hold");

  a_step_by_one: assert property (
    advance && !countWrite && !(st_r.pending && extRise)
    |=> st_r.count == $past(st_r.count) + COUNT_STEP)
    else $error("count did not step by one");

  a_psc_off_clear: assert property (!cfg.enable |=> st_r.psc == 8'h00)
    else $error("prescaler kept while disabled");

  // prescaler, gate start and start-up wait checks
  a_psc_dev_clear: assert property (deviceResetNoPor |=> st_r.psc == 8'h00)
    else $error("prescaler kept on device reset");

  a_gate_rise_run: assert property (
    gatedMode && cfg.enable && extRise |=> st_r.gateRun)
    else $error("gate rise did not start timer");

  a_arm_first_edge: assert property (
    st_r.run == RUN_ARM && st_r.startEdges == 2'h0 && cfg.enable
    |=> st_r.run == RUN_ARM)
    else $error("counting began before two pin edges");

endmodule

/* sim/pin_source.sv */
// far-side model: pulse source or gate level on the timer pin
module pin_source (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [9:0] pulses,
  input  wire logic       gateLevel,
  output logic            pinOut,
  output logic            busy
);
  // ==========================================================
  // pulse train state
  logic [9:0] left;  // pulses still to finish
  logic [1:0] ph;    // cycles spent in current half
  logic       hi;    // current pulse level

  // each half lasts three clocks, above the two-clock pin minimum
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left <= '0;
      ph   <= '0;
      hi   <= 1'b0;
    end else if (start) begin
      left <= pulses;
      ph   <= '0;
      hi   <= 1'b0;
    end else if (left != 10'h000) begin
      if (ph == 2'h2) begin
        ph <= '0;
        hi <= !hi;
        // a pulse is done when its high half ends
        if (hi) begin
          left <= left - 10'h001;
        end
      end else begin
        ph <= ph + 2'h1;
      end
    end
  end

  // clock stands still between trains; gate level shows otherwise
  assign pinOut = (left != 10'h000) ? hi : gateLevel;
  assign busy   = (left != 10'h000);
endmodule

/* sim/test_async_gated_interval_timer.sv */
// self-checking bench of the gated interval timer
module test_async_gated_interval_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  // ==========================================================
  // signals
  logic        clock, rstn, deviceResetNoPor, sleepMode, countWrite;
  logic        flagClear, pinOut, start, gateLevel, busy;
  timer_cfg_s  cfg;                        // control bits
  irq_cfg_s    irqCfg;                     // interrupt settings
  logic [15:0] countWriteData, periodValue, countValue, rnd, a, b, v;
  logic        asyncWritePending, timerEventFlag, irqRequest;
  logic        matchEvent, gateEvent;
  logic [2:0]  irqPriorityOut;
  logic [1:0]  irqSubpriorityOut;
  logic [9:0]  pulses;
  int          errors, compares, cyc, nMatch, nGate, j, p, g;

  gated_interval_timer uut (.clock(clock), .rstn(rstn),
    .deviceResetNoPor(deviceResetNoPor), .cfg(cfg), .irqCfg(irqCfg),
    .extClockGatePin(pinOut), .sleepMode(sleepMode),
    .countWrite(countWrite), .countWriteData(countWriteData),
    .periodValue(periodValue), .flagClear(flagClear),
    .countValue(countValue), .asyncWritePending(asyncWritePending),
    .timerEventFlag(timerEventFlag), .irqRequest(irqRequest),
    .irqPriorityOut(irqPriorityOut),
    .irqSubpriorityOut(irqSubpriorityOut),
    .matchEvent(matchEvent), .gateEvent(gateEvent));

  pin_source src (.clock(clock), .rstn(rstn), .start(start),
    .pulses(pulses), .gateLevel(gateLevel), .pinOut(pinOut),
    .busy(busy));

  // ==========================================================
  // helpers
  always #12.5 clock = ~clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // send n pin clock edges, then let the read path settle
  task automatic edges(input int n);
    pulses = n[9:0];
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int i = 0; i < 4000 && busy; i++) begin
      tick(1);
    end
    tick(8);
  endtask

  task automatic wr(input logic [15:0] d);
    countWrite = 1'b1;
    countWriteData = d;
    tick(1);
    countWrite = 1'b0;
  endtask

  // settings change only while disabled
  task automatic setCfg(input logic cs, gt, input logic [1:0] ps,
                        input logic blk);
    cfg = '{enable: 1'b0, clockSourceSelect: cs, extSyncSelect: 1'b0,
            prescaleSelect: ps, gateAccumEnable: gt,
            asyncWriteBlock: blk};
    tick(1);
  endtask

  task automatic clearAll();
    setCfg(1'b0, 1'b0, 2'h0, 1'b0);
    wr(16'h0000);
    flagClear = 1'b1;
    tick(1);
    flagClear = 1'b0;
  endtask

  // event tallies and hang guard
  always @(posedge clock) begin
    cyc++;
    if (matchEvent === 1'b1) nMatch++;
    if (gateEvent === 1'b1) nGate++;
    if (cyc == 40000) begin
      errors++;
      test_done();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0; rstn = 1'b0; deviceResetNoPor = 1'b0; sleepMode = 1'b0;
    countWrite = 1'b0; flagClear = 1'b0; start = 1'b0; gateLevel = 1'b0;
    cfg = '0; irqCfg = '0; countWriteData = '0; pulses = '0;
    periodValue = 16'hFFFF; rnd = 16'h001F;
    repeat (16) @(posedge clock);
    #2;
    rstn = 1'b1;
    tick(2);
    // async counting at every prescale, two start edges first
    for (int s = 0; s < 4; s++) begin
      rnd = lfsr(rnd);
      j = 1 + (int'(rnd[3:0]) >> s);
      clearAll();
      setCfg(1'b1, 1'b0, s[1:0], 1'b0);
      cfg.enable = 1'b1;
      sleepMode = 1'b1;
      edges(2 + ((s == 3) ? 256 : (1 << (3 * s))) * j);
      check(countValue, 16'(j));
      cfg.enable = 1'b0;
      tick(1);
      edges(5);
      check(countValue, 16'(j));
      sleepMode = 1'b0;
    end
    // async period match and wrap
    rnd = lfsr(rnd);
    p = 2 + int'(rnd[2:0]);
    clearAll();
    setCfg(1'b1, 1'b0, 2'h0, 1'b0);
    periodValue = 16'(p);
    nMatch = 0;
    cfg.enable = 1'b1;
    edges(2 + 3 * (p + 1) + 1);
    check(16'(nMatch), 16'h0003);
    check(countValue, 16'h0001);
    // async writes with blocking off and on
    for (int k = 0; k < 2; k++) begin
      setCfg(1'b1, 1'b0, 2'h0, k[0]);
      rnd = lfsr(rnd);
      a = rnd;
      rnd = lfsr(rnd);
      b = rnd;
      countWrite = 1'b1;
      countWriteData = a;
      tick(1);
      // legacy mode waits for pending to drop; blocking mode writes at once
      countWrite = k[0];
      countWriteData = b;
      tick(1);
      countWrite = 1'b0;
      check(16'(asyncWritePending), 16'h0001);
      edges(3);
      check(16'(asyncWritePending), 16'h0000);
      check(countValue, a);
      wr(b);
      edges(3);
      check(countValue, b);
    end
    // synchronous mode write: no pending, immediate
    setCfg(1'b0, 1'b0, 2'h0, 1'b1);
    wr(b ^ 16'h5A5A);
    check(16'(asyncWritePending), 16'h0000);
    tick(1);
    check(countValue, b ^ 16'h5A5A);
    // prescaler cleared by a device reset and by a count write
    clearAll();
    setCfg(1'b0, 1'b0, PSC_SEL_8, 1'b0);
    periodValue = 16'hFFFF;
    cfg.enable = 1'b1;
    tick(6);
    deviceResetNoPor = 1'b1;
    tick(1);
    deviceResetNoPor = 1'b0;
    tick(7);
    check(countValue, 16'h0000);
    tick(1);
    check(countValue, 16'h0001);
    tick(4);
    wr(16'h0010);
    tick(7);
    check(countValue, 16'h0010);
    tick(1);
    check(countValue, 16'h0011);
    // internal 1:1 match pulses and flag timing
    rnd = lfsr(rnd);
    p = 2 + int'(rnd[2:0]);
    periodValue = 16'(p);
    clearAll();
    cfg.enable = 1'b1;
    tick(1);
    for (int k = 1; k <= 3 * p + 3; k++) begin
      tick(1);
      check(16'({matchEvent, timerEventFlag}),
            16'({(k + 1) % (p + 1) == 0, k > p}));
    end
    cfg.enable = 1'b0;
    // interrupt request over every priority level
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      irqCfg = '{timerIrqEnable: rnd[0] | i[0], irqPriority: i[2:0],
                 irqSubpriority: rnd[2:1]};
      tick(2);
      check(16'(irqRequest), 16'((rnd[0] | i[0]) && i != 0));
      check(16'({irqPriorityOut, irqSubpriorityOut}),
            16'({i[2:0], rnd[2:1]}));
    end
    check(16'(timerEventFlag), 16'h0001);
    flagClear = 1'b1;
    tick(1);
    flagClear = 1'b0;
    tick(1);
    check(16'(timerEventFlag), 16'h0000);
    // gated accumulation, long and short period
    for (int k = 0; k < 2; k++) begin
      clearAll();
      setCfg(1'b0, 1'b1, 2'h0, 1'b0);
      cfg.extSyncSelect = k[0];
      periodValue = k[0] ? 16'h0005 : 16'hFFFF;
      nMatch = 0;
      nGate = 0;
      cfg.enable = 1'b1;
      tick(2);
      rnd = lfsr(rnd);
      g = 20 + int'(rnd[4:0]);
      gateLevel = 1'b1;
      tick(g);
      gateLevel = 1'b0;
      tick(8);
      v = countValue;
      check(16'(nGate), 16'h0001);
      check(16'(nMatch), 16'h0000);
      check(16'(timerEventFlag), 16'h0001);
      if (k[0]) check(16'(v <= 16'h0005), 16'h0001);
      else check(16'(v >= 16'(g - 2) && v <= 16'(g + 1)), 16'h0001);
      tick(10);
      check(countValue, v);
    end
    test_done();
  end
endmodule
